// ===== src/ra_pkg.sv
// constants for the alarm-2, alarm-1 year and countdown register block
package ra_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_A1_YEAR   = 8'h12;
    localparam logic [7:0] ADDR_A2_MIN    = 8'h13;
    localparam logic [7:0] ADDR_A2_HOUR   = 8'h14;
    localparam logic [7:0] ADDR_A2_DAYDT  = 8'h15;
    localparam logic [7:0] ADDR_CNT_CUR   = 8'h16;
    localparam logic [7:0] ADDR_CNT_LOAD  = 8'h17;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         MASK_BIT       = 7;    // mask in every alarm-2 reg
    localparam int         DYDT_BIT       = 6;    // weekday/monthday select
    localparam logic [7:0] HOUR_WR_MASK   = 8'hbf; // bit 6 unused in hours
    localparam logic [7:0] RESET_VAL      = 8'h00; // every register resets 0
    localparam logic [7:0] READ_UNMAPPED  = 8'h00; // answer to other offsets
    localparam logic [7:0] CNT_ONE        = 8'h01;

endpackage : ra_pkg

// ===== src/ra_alarm_timer.sv
// alarm-2 compare, alarm-1 year compare and countdown timer registers
`timescale 1ns/1ps

module ra_alarm_timer #(
    parameter int DW = 8                           // register data width
) (
    // clock and reset
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    // register port from the serial interface engine
    input  wire logic [7:0]    reg_addr_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    input  wire logic [DW-1:0] reg_wdata_i,
    output logic      [DW-1:0] reg_rdata_o,
    // timekeeping values, BCD
    input  wire logic          sec_rollover_i,     // seconds went to 00
    input  wire logic [7:0]    time_min_i,
    input  wire logic [7:0]    time_hour_i,
    input  wire logic [7:0]    time_date_i,
    input  wire logic [7:0]    time_weekday_i,
    input  wire logic [7:0]    time_year_i,
    // interrupt control
    input  wire logic          alarm2_irq_enable_i,
    input  wire logic          alarm1_year_mask_i,
    // countdown control
    input  wire logic          timer_enable_i,
    input  wire logic          timer_repeat_i,
    input  wire logic          timer_tick_i,       // one pulse per timer step
    // results
    output logic               alarm2_event_o,     // alarm-2 match pulse
    output logic               alarm2_irq_o,       // interrupt request pulse
    output logic               year_match_o,       // year term for alarm 1
    output logic               timer_expire_o      // count reached zero
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [DW-1:0] alarm1_year_compare;     // year tens 7:4, units 3:0
    logic [DW-1:0] alarm2_minute_compare;   // mask, tens 6:4, units 3:0
    logic [DW-1:0] alarm2_hour_compare;     // mask, tens 5:4, units 3:0
    logic [DW-1:0] alarm2_daydate_compare;  // mask, select, tens, units
    logic [DW-1:0] countdown_current_value; // running count
    logic [DW-1:0] countdown_reload_value;  // value loaded at zero

    // decoded fields
    logic          alarm2_minute_mask;
    logic          alarm2_hour_mask;
    logic          alarm2_daydate_mask;
    logic          weekday_or_monthday_select;
    logic [1:0]    hour_tens;
    logic          min_eq;
    logic          hour_eq;
    logic          dd_eq;
    logic          alarm2_hit;              // compare result this cycle

    // ------------------------------------------------------------
    // alarm compare and countdown reload registers
    // ------------------------------------------------------------
    // host writes; each register keeps all bits except unused hour bit
    // alarm-2 register decode
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            alarm2_minute_compare  <= ra_pkg::RESET_VAL;
            alarm2_hour_compare    <= ra_pkg::RESET_VAL;
            alarm2_daydate_compare <= ra_pkg::RESET_VAL;
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == ra_pkg::ADDR_A2_MIN)
                alarm2_minute_compare <= reg_wdata_i;
            if (reg_addr_i == ra_pkg::ADDR_A2_HOUR)
                alarm2_hour_compare <= reg_wdata_i & ra_pkg::HOUR_WR_MASK;
            if (reg_addr_i == ra_pkg::ADDR_A2_DAYDT)
                alarm2_daydate_compare <= reg_wdata_i;
        end
    end

    // year compare register
    // year register, reset zero
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            alarm1_year_compare <= ra_pkg::RESET_VAL;
        else if (reg_wr_i && reg_addr_i == ra_pkg::ADDR_A1_YEAR)
            alarm1_year_compare <= reg_wdata_i;
    end

    // reload register
    // reload value storage
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            countdown_reload_value <= ra_pkg::RESET_VAL;
        else if (reg_wr_i && reg_addr_i == ra_pkg::ADDR_CNT_LOAD)
            countdown_reload_value <= reg_wdata_i;
    end

    // ------------------------------------------------------------
    // alarm-2 match logic
    // ------------------------------------------------------------
    assign alarm2_minute_mask  = alarm2_minute_compare[ra_pkg::MASK_BIT];
    assign alarm2_hour_mask    = alarm2_hour_compare[ra_pkg::MASK_BIT];
    assign alarm2_daydate_mask = alarm2_daydate_compare[ra_pkg::MASK_BIT];
    assign weekday_or_monthday_select =
        alarm2_daydate_compare[ra_pkg::DYDT_BIT];
    assign hour_tens = alarm2_hour_compare[5:4];

    // field equality, BCD compare on the used bits only
    always_comb
    begin
        min_eq  = (alarm2_minute_compare[6:0] == time_min_i[6:0]);
        hour_eq = ({hour_tens, alarm2_hour_compare[3:0]}
                   == time_hour_i[5:0]);
        // date when 0, weekday when 1
        if (weekday_or_monthday_select)
            dd_eq = (alarm2_daydate_compare[5:0] == time_weekday_i[5:0]);
        else
            dd_eq = (alarm2_daydate_compare[5:0] == time_date_i[5:0]);
    end

    // each field passes when masked or equal; all-masked fires each minute
    // masked fields ignored
    assign alarm2_hit = (alarm2_minute_mask  || min_eq)
                     && (alarm2_hour_mask    || hour_eq)
                     && (alarm2_daydate_mask || dd_eq);

    // evaluated only on the rollover pulse; one-cycle result pulses
    // sample at seconds rollover
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            alarm2_event_o <= 1'b0;
            alarm2_irq_o   <= 1'b0;
        end
        else
        begin
            alarm2_event_o <= sec_rollover_i && alarm2_hit;
            alarm2_irq_o   <= sec_rollover_i && alarm2_hit
                              && alarm2_irq_enable_i;
        end
    end

    // ------------------------------------------------------------
    // alarm-1 year term
    // ------------------------------------------------------------
    // year matters only when unmasked
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            year_match_o <= 1'b0;
        else
            year_match_o <= alarm1_year_mask_i
                            || (alarm1_year_compare == time_year_i);
    end

    // ------------------------------------------------------------
    // countdown timer
    // ------------------------------------------------------------
    // while disabled the count follows the reload value, so enabling
    // starts from it; host writes to the count offset are ignored
    // count changes only by the timer or by following the reload value
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            countdown_current_value <= ra_pkg::RESET_VAL;
        else if (!timer_enable_i)
            countdown_current_value <= countdown_reload_value;
        else if (timer_tick_i)
        begin
            // reload at zero in repeat mode
            if (countdown_current_value == ra_pkg::RESET_VAL)
            begin
                if (timer_repeat_i)
                    countdown_current_value <= countdown_reload_value;
            end
            else
                countdown_current_value <= countdown_current_value
                                           - ra_pkg::CNT_ONE;
        end
    end

    // pulse when the count steps from one to zero
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            timer_expire_o <= 1'b0;
        else
            timer_expire_o <= timer_enable_i && timer_tick_i
                && countdown_current_value == ra_pkg::CNT_ONE;
    end

    // ------------------------------------------------------------
    // register read-back
    // ------------------------------------------------------------
    // read data registered, valid the cycle after reg_rd_i
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= ra_pkg::RESET_VAL;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                ra_pkg::ADDR_A1_YEAR:  reg_rdata_o <= alarm1_year_compare;
                ra_pkg::ADDR_A2_MIN:   reg_rdata_o <= alarm2_minute_compare;
                ra_pkg::ADDR_A2_HOUR:  reg_rdata_o <= alarm2_hour_compare;
                ra_pkg::ADDR_A2_DAYDT: reg_rdata_o <= alarm2_daydate_compare;
                ra_pkg::ADDR_CNT_CUR:  reg_rdata_o <= countdown_current_value;
                ra_pkg::ADDR_CNT_LOAD: reg_rdata_o <= countdown_reload_value;
                default:               reg_rdata_o <= ra_pkg::READ_UNMAPPED;
            endcase
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // interrupt needs enable
    chk_irq_gated: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        alarm2_irq_o |-> alarm2_event_o && $past(alarm2_irq_enable_i))
        else $error("alarm-2 interrupt without event or enable");

    chk_event_at_rollover: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        alarm2_event_o |-> $past(sec_rollover_i))
        else $error("alarm-2 event outside seconds rollover");

    chk_all_masked_fires: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        sec_rollover_i && alarm2_minute_mask && alarm2_hour_mask
        && alarm2_daydate_mask |=> alarm2_event_o)
        else $error("fully masked alarm-2 did not fire");

    chk_minute_mismatch: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        sec_rollover_i && !alarm2_minute_mask
        && alarm2_minute_compare[6:0] != time_min_i[6:0]
        |=> !alarm2_event_o)
        else $error("alarm-2 fired on minute mismatch");

    chk_date_select: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        sec_rollover_i && !alarm2_daydate_mask && !weekday_or_monthday_select
        && alarm2_daydate_compare[5:0] != time_date_i[5:0]
        |=> !alarm2_event_o)
        else $error("alarm-2 fired on date mismatch");

    chk_hour_bit6_zero: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == ra_pkg::ADDR_A2_HOUR
        |=> reg_rdata_o[6] == 1'b0)
        else $error("unused hour bit read as one");

    chk_count_readonly: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == ra_pkg::ADDR_CNT_CUR && timer_enable_i
        && !timer_tick_i |=> $stable(countdown_current_value))
        else $error("write changed the running count");

    chk_repeat_reload: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        timer_enable_i && timer_repeat_i && timer_tick_i
        && countdown_current_value == ra_pkg::RESET_VAL
        |=> countdown_current_value == $past(countdown_reload_value))
        else $error("count not reloaded at zero");

    chk_year_masked: assert property (@(posedge mclk_i)
        disable iff (!rst_n_i)
        alarm1_year_mask_i |=> year_match_o)
        else $error("masked year term not true");

    chk_year_reset: assert property (@(posedge mclk_i)
        $past(!rst_n_i) |-> alarm1_year_compare == ra_pkg::RESET_VAL)
        else $error("year compare not zero after reset");

    cov_alarm_irq: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        alarm2_irq_o);
    cov_weekday_hit: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        alarm2_event_o && weekday_or_monthday_select && !alarm2_daydate_mask);
    cov_timer_reload: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        timer_expire_o ##[1:300] timer_expire_o);

endmodule : ra_alarm_timer

// ===== sim/ra_host_model.sv
// host model: single-byte register accesses towards the block
`timescale 1ns/1ps
module ra_host_model (
    // clock
    input  wire logic       mclk_i,
    // register port
    output logic [7:0]      reg_addr_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    // idle port at time zero
    initial
    begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // write strobe for one edge at any offset, data then released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(negedge mclk_i);
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~d;    // released data shows no stale value
    endtask : wr
    // read strobe for one edge, data taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(negedge mclk_i);
        reg_rd_o   = 1'b0;
        d          = reg_rdata_i;
    endtask : rd
endmodule : ra_host_model

// ===== sim/tb.sv
// self-checking testbench for the alarm and countdown register block
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       mclk_i, rst_n_i;          // clock, reset
    logic [7:0] r_addr, r_wdata, r_rdata; // register port
    logic       r_wr, r_rd;
    logic       roll, irq_en, ymask;       // alarm controls
    logic [7:0] t_min, t_hour, t_date, t_wday, t_year;
    logic       t_en, t_rep, tick;         // countdown controls
    logic       ev, irq, ymatch, expire;   // results
    logic [7:0] d;                          // read-back byte
    int         failures, check_count;
    // ------------------------------------------------------------
    // design and host model
    // ------------------------------------------------------------
    ra_alarm_timer u_ra_alarm_timer (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(r_addr), .reg_wr_i(r_wr), .reg_rd_i(r_rd),
        .reg_wdata_i(r_wdata), .reg_rdata_o(r_rdata),
        .sec_rollover_i(roll), .time_min_i(t_min), .time_hour_i(t_hour),
        .time_date_i(t_date), .time_weekday_i(t_wday),
        .time_year_i(t_year), .alarm2_irq_enable_i(irq_en),
        .alarm1_year_mask_i(ymask), .timer_enable_i(t_en),
        .timer_repeat_i(t_rep), .timer_tick_i(tick),
        .alarm2_event_o(ev), .alarm2_irq_o(irq), .year_match_o(ymatch),
        .timer_expire_o(expire));
    ra_host_model u_ra_host_model (.mclk_i(mclk_i), .reg_addr_o(r_addr),
        .reg_wr_o(r_wr), .reg_rd_o(r_rd), .reg_wdata_o(r_wdata),
        .reg_rdata_i(r_rdata));
    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // ten thousand cycles, far longer than the run of under two hundred
    initial
    begin
        #100000;
        failures++;
        end_of_test();
    end
    // compare one byte and count it
    task automatic chk(input string w, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    // read a register and compare
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        u_ra_host_model.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask : rdc
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // reset values of every register and an unmapped offset
    task automatic test_reset;
        for (int a = 8'h12; a <= 8'h17; a++)
            rdc(8'(a), 8'h00);
        rdc(8'h20, 8'h00);
        $display("test_reset done");
    endtask : test_reset
    // write/read of each field, read-only count, unused hour bit
    task automatic test_regs;
        u_ra_host_model.wr(8'h12, 8'h99);
        rdc(8'h12, 8'h99);
        u_ra_host_model.wr(8'h13, 8'hff);
        rdc(8'h13, 8'hff);
        u_ra_host_model.wr(8'h14, 8'hff);
        rdc(8'h14, 8'hbf);
        u_ra_host_model.wr(8'h15, 8'hff);
        rdc(8'h15, 8'hff);
        u_ra_host_model.wr(8'h17, 8'ha5);
        u_ra_host_model.wr(8'h16, 8'h3c);
        rdc(8'h16, 8'ha5);
        u_ra_host_model.wr(8'h20, 8'h77);
        rdc(8'h20, 8'h00);
        $display("test_regs done");
    endtask : test_regs
    // year term against stored year and mask
    task automatic test_year;
        u_ra_host_model.wr(8'h12, 8'h47);
        t_year = 8'h46;
        @(negedge mclk_i);
        chk("year_match", 8'h00, {7'h0, ymatch});
        t_year = 8'h47;
        @(negedge mclk_i);
        chk("year_match", 8'h01, {7'h0, ymatch});
        t_year = 8'h46;
        ymask  = 1'b1;
        @(negedge mclk_i);
        chk("year_match", 8'h01, {7'h0, ymatch});
        ymask  = 1'b0;
        $display("test_year done");
    endtask : test_year
    // each listed mask setting, hit and miss; time 12:30 date 15 day 3
    task automatic test_alarm;
        logic [7:0] tab [10][4] = '{
            '{8'hc5, 8'h80, 8'h80, 1}, '{8'h30, 8'h80, 8'h80, 1},
            '{8'h31, 8'h80, 8'h80, 0}, '{8'h30, 8'h12, 8'h80, 1},
            '{8'h30, 8'h13, 8'h80, 0}, '{8'h30, 8'h12, 8'h15, 1},
            '{8'h30, 8'h12, 8'h16, 0}, '{8'h30, 8'h12, 8'h43, 1},
            '{8'h30, 8'h12, 8'h55, 0}, '{8'h30, 8'h12, 8'h44, 0}};
        for (int i = 0; i < 10; i++)
        begin
            u_ra_host_model.wr(8'h13, tab[i][0]);
            u_ra_host_model.wr(8'h14, tab[i][1]);
            u_ra_host_model.wr(8'h15, tab[i][2]);
            irq_en = i[0];
            @(negedge mclk_i);
            chk("event idle", 8'h00, {7'h0, ev});
            roll = 1'b1;
            @(negedge mclk_i);
            roll = 1'b0;
            chk("event", tab[i][3], {7'h0, ev});
            chk("irq", tab[i][3] & 8'(i[0]), {7'h0, irq});
            @(negedge mclk_i);
            chk("event end", 8'h00, {7'h0, ev});
        end
        $display("test_alarm done");
    endtask : test_alarm
    // one tick, returning expire from the following cycle
    task automatic step(input logic [7:0] e_exp, input logic [7:0] c_exp);
        @(negedge mclk_i);
        tick = 1'b1;
        @(negedge mclk_i);
        tick = 1'b0;
        chk("expire", e_exp, {7'h0, expire});
        rdc(8'h16, c_exp);
    endtask : step
    // countdown from 2, stop at zero, then reload in repeat mode
    task automatic test_timer;
        u_ra_host_model.wr(8'h17, 8'h02);
        rdc(8'h16, 8'h02);
        t_en = 1'b1;
        // a write to the running count is ignored
        u_ra_host_model.wr(8'h16, 8'h55);
        rdc(8'h16, 8'h02);
        step(8'h00, 8'h01);
        step(8'h01, 8'h00);
        step(8'h00, 8'h00);
        t_rep = 1'b1;
        step(8'h00, 8'h02);
        $display("test_timer done");
    endtask : test_timer
    // counts, verdict and stop
    task automatic end_of_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        failures = 0;
        check_count = 0;
        rst_n_i = 1'b0;
        {roll, irq_en, ymask, t_en, t_rep, tick} = 6'h00;
        {t_min, t_hour, t_date, t_wday} = {8'h30, 8'h12, 8'h15, 8'h03};
        t_year = 8'h00;
        repeat (16) @(posedge mclk_i);
        @(negedge mclk_i);
        rst_n_i = 1'b1;
        test_reset();
        test_regs();
        test_year();
        test_alarm();
        test_timer();
        end_of_test();
    end
endmodule : tb
